// file: wdog_ctl_defs.vh
// Constants for the watchdog control and status block
`ifndef WDOG_CTL_DEFS_VH
`define WDOG_CTL_DEFS_VH
// Special function register addresses
`define ADDR_TIMED_ACCESS_KEY   8'hc7
`define ADDR_WATCHDOG_CONTROL   8'hd8
`define ADDR_EXT_IRQ_ENABLE     8'he8
`define ADDR_EXT_IRQ_PRIORITY   8'hf8
// Timed-access key values
`define TA_KEY_FIRST            8'haa
`define TA_KEY_SECOND           8'h55
// Watchdog control bit positions
`define BIT_BAUD_DOUBLE         7
`define BIT_POWER_ON_FLAG       6
`define BIT_IRQ_FLAG            3
`define BIT_RESET_FLAG          2
`define BIT_RESET_ENABLE        1
`define BIT_RESTART             0
// Extended enable/priority bit of the watchdog interrupt
`define BIT_WDOG_IRQ            4
// Reserved upper bits of the enable register read high
`define EIE_RESERVED_ONES       8'he0
// Reset values
`define EIE_RESET               5'h00
`define EIP_RESET               5'h00
// Delay from time-out to watchdog reset, in core clocks
`define WDOG_RESET_DELAY        10'd512
`endif

// file: timed_access_unlock.v
// Timed-access key sequencer granting one protected write window
`timescale 1ns/1ps
`default_nettype none
`include "wdog_ctl_defs.vh"
module timed_access_unlock
(
   // Clock and reset
   input  wire       clock,
   input  wire       rst_n,
   // Special function register write port
   input  wire       sfr_wr,
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   // Unlock state
   output reg        unlocked
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_HALF = 3'b010;
   localparam [2:0] ST_OPEN = 3'b100;

   reg  [2:0] state;
   reg  [2:0] next_state;
   wire       key_wr;

   assign key_wr = sfr_wr && (sfr_addr == `ADDR_TIMED_ACCESS_KEY);

   // Any write other than the exact next key aborts; the window closes after one write
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (key_wr && sfr_wdata == `TA_KEY_FIRST)
               next_state = ST_HALF;
         end
         ST_HALF:
         begin
            if (key_wr && sfr_wdata == `TA_KEY_SECOND)
               next_state = ST_OPEN;
            else if (sfr_wr)
               next_state = ST_IDLE;
         end
         ST_OPEN:
         begin
            if (sfr_wr)
               next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   // State register
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         state    <= ST_IDLE;
         unlocked <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         unlocked <= (next_state == ST_OPEN);
      end
   end
endmodule // timed_access_unlock
`default_nettype wire

// file: wdog_ctl.v
// Watchdog control flags, extended interrupt enable and priority registers
`timescale 1ns/1ps
`default_nettype none
`include "wdog_ctl_defs.vh"
module wdog_ctl
(
   // Clock and synchronous core reset
   input  wire       clock,
   input  wire       rst_n,
   // Reset cause, sampled during rst_n low
   input  wire       por_event,
   input  wire       power_fail_event,
   input  wire       wdog_reset_event,
   // Special function register port
   input  wire       sfr_wr,
   input  wire       sfr_rd,
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   output reg  [7:0] sfr_rdata,
   // Watchdog counter interface
   input  wire       wdog_timeout,
   output reg        wdog_restart_pulse,
   // Outputs to the rest of the chip
   output reg        wdog_chip_reset,
   output reg        wdog_irq_req,
   output reg        wdog_irq_priority,
   output reg  [3:0] ext_irq_enable,
   output reg  [3:0] ext_irq_priority,
   output reg        second_serial_baud_double
);
   reg        power_on_flag;
   reg        wdog_irq_flag;
   reg        wdog_reset_flag;
   reg        wdog_reset_enable;
   reg        wdog_restart;
   reg        wdog_irq_enable;
   reg        delay_run;
   reg  [9:0] delay_cnt;
   reg  [7:0] rd_mux;
   wire       unlocked;
   wire       wr_ctl;
   wire       wr_prot;
   wire       wr_eie;
   wire       wr_eip;
   wire [2:0] sfr_sel;

   // One-hot register select; the write strobes and the read mux share it
   function [2:0] sfr_select;
      input [7:0] addr;
   begin
      if (addr == `ADDR_WATCHDOG_CONTROL)
         sfr_select = 3'h1;
      else if (addr == `ADDR_EXT_IRQ_ENABLE)
         sfr_select = 3'h2;
      else if (addr == `ADDR_EXT_IRQ_PRIORITY)
         sfr_select = 3'h4;
      else
         sfr_select = 3'h0;
   end
   endfunction

   timed_access_unlock timed_access_unlock_inst
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .sfr_wr   (sfr_wr),
      .sfr_addr (sfr_addr),
      .sfr_wdata(sfr_wdata),
      .unlocked (unlocked)
   );

   // Write strobes; protected bits need the open window
   assign sfr_sel = sfr_select(sfr_addr);
   assign wr_ctl  = sfr_wr && sfr_sel[0];
   assign wr_prot = wr_ctl && unlocked;
   assign wr_eie  = sfr_wr && sfr_sel[1];
   assign wr_eip  = sfr_wr && sfr_sel[2];

   // Watchdog control register; power-on, reset and enable flags live across rst_n so reset kind picks their values
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         second_serial_baud_double <= 1'b0;
         wdog_irq_flag             <= 1'b0;
         wdog_restart              <= 1'b0;
         // Only a power-on raises the flag and turns the reset function off
         if (por_event)
         begin
            power_on_flag     <= 1'b1;
            wdog_reset_enable <= 1'b0;
         end
         // Power resets clear the cause flag; with the function off a watchdog reset leaves it
         if (por_event || power_fail_event)
            wdog_reset_flag <= 1'b0;
         else if (wdog_reset_event && wdog_reset_enable)
            wdog_reset_flag <= 1'b1;
      end
      else
      begin
         // Software writes once out of reset
         if (wr_ctl)
            second_serial_baud_double <= sfr_wdata[`BIT_BAUD_DOUBLE];
         if (wr_ctl)
            wdog_reset_flag <= sfr_wdata[`BIT_RESET_FLAG];
         if (wr_prot)
         begin
            power_on_flag     <= sfr_wdata[`BIT_POWER_ON_FLAG];
            wdog_reset_enable <= sfr_wdata[`BIT_RESET_ENABLE];
         end
         // Time-out set wins over a same-cycle software clear
         if (wdog_timeout)
            wdog_irq_flag <= 1'b1;
         else if (wr_prot)
            wdog_irq_flag <= sfr_wdata[`BIT_IRQ_FLAG];
         // Restart bit is visible for one cycle, then clears itself
         wdog_restart <= wr_prot && sfr_wdata[`BIT_RESTART];
      end
   end

   // Time-out to reset delay; a restart cancels a pending reset
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         delay_run       <= 1'b0;
         delay_cnt       <= 10'd0;
         wdog_chip_reset <= 1'b0;
      end
      else
      begin
         // Reset output is a single-cycle pulse
         wdog_chip_reset <= 1'b0;
         // Restart wins over a time-out in the same cycle, so a late kick still saves the chip
         if (wdog_restart)
         begin
            delay_run <= 1'b0;
            delay_cnt <= 10'd0;
         end
         else if (wdog_timeout && !delay_run)
         begin
            delay_run <= 1'b1;
            delay_cnt <= 10'd1;
         end
         else if (delay_run)
         begin
            if (delay_cnt == `WDOG_RESET_DELAY)
            begin
               delay_run       <= 1'b0;
               delay_cnt       <= 10'd0;
               // Enable is looked at when the count ends, so clearing it late still blocks the reset
               wdog_chip_reset <= wdog_reset_enable;
            end
            else
               delay_cnt <= delay_cnt + 10'd1;
         end
      end
   end

   // Extended enable and priority registers, plus the request line
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         {wdog_irq_enable, ext_irq_enable}     <= `EIE_RESET;
         {wdog_irq_priority, ext_irq_priority} <= `EIP_RESET;
         wdog_irq_req                          <= 1'b0;
         wdog_restart_pulse                    <= 1'b0;
      end
      else
      begin
         // Only the low five bits hold state; the upper ones are fixed in the read mux
         if (wr_eie)
            {wdog_irq_enable, ext_irq_enable} <= sfr_wdata[4:0];
         if (wr_eip)
            {wdog_irq_priority, ext_irq_priority} <= sfr_wdata[4:0];
         // Request lags the flag by one cycle so the output comes from a flop
         wdog_irq_req       <= wdog_irq_flag && wdog_irq_enable;
         wdog_restart_pulse <= wr_prot && sfr_wdata[`BIT_RESTART];
      end
   end

   // Read mux; unmapped addresses read zero
   always @*
   begin
      // Reserved control bits 5:4 and priority bits 7:5 read as zero
      if (sfr_sel[0])
         rd_mux = {second_serial_baud_double, power_on_flag, 2'b00, wdog_irq_flag,
                   wdog_reset_flag, wdog_reset_enable, wdog_restart};
      else if (sfr_sel[1])
         rd_mux = `EIE_RESERVED_ONES | {3'b000, wdog_irq_enable, ext_irq_enable};
      else if (sfr_sel[2])
         rd_mux = {3'b000, wdog_irq_priority, ext_irq_priority};
      else
         rd_mux = 8'h00;
   end

   // Registered read data, valid the cycle after sfr_rd
   always @(posedge clock)
   begin
      if (!rst_n)
         sfr_rdata <= 8'h00;
      else if (sfr_rd)
         sfr_rdata <= rd_mux;
   end
endmodule // wdog_ctl
`default_nettype wire

// file: wdog_ctl_assertions.sv
// Port-level assertions for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdog_ctl_assertions
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // Register port
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Watchdog side and outputs
   input wire logic       wdog_timeout,
   input wire logic       wdog_restart_pulse,
   input wire logic       wdog_chip_reset,
   input wire logic       wdog_irq_priority,
   input wire logic [3:0] ext_irq_enable,
   input wire logic [3:0] ext_irq_priority,
   input wire logic       second_serial_baud_double
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Pulses to the counter and the chip trace back to their cause
   property p_restart_cause; $rose(wdog_restart_pulse) |-> $past(sfr_wr && sfr_addr == 8'hd8 && sfr_wdata[0]); endproperty
   a_restart_cause: assert property (p_restart_cause) else $error("restart pulse without a write");
   property p_reset_delay; $rose(wdog_chip_reset) |-> $past(wdog_timeout, 513); endproperty
   a_reset_delay: assert property (p_reset_delay) else $error("chip reset off the time-out delay");
   property p_reset_once; wdog_chip_reset |=> !wdog_chip_reset; endproperty
   a_reset_once: assert property (p_reset_once) else $error("chip reset longer than a cycle");
   // Register writes reach their outputs one cycle later
   property p_enable_wr; sfr_wr && sfr_addr == 8'he8 |=> ext_irq_enable == $past(sfr_wdata[3:0]); endproperty
   a_enable_wr: assert property (p_enable_wr) else $error("enable bits not written");
   property p_prio_wr; sfr_wr && sfr_addr == 8'hf8 |=> {wdog_irq_priority, ext_irq_priority} == $past(sfr_wdata[4:0]); endproperty
   a_prio_wr: assert property (p_prio_wr) else $error("priority bits not written");
   property p_baud_wr; sfr_wr && sfr_addr == 8'hd8 |=> second_serial_baud_double == $past(sfr_wdata[7]); endproperty
   a_baud_wr: assert property (p_baud_wr) else $error("baud double bit not written");
   // Read data: reserved enable bits high, value held between reads
   property p_enable_read; sfr_rd && sfr_addr == 8'he8 |=> sfr_rdata[7:5] == 3'b111; endproperty
   a_enable_read: assert property (p_enable_read) else $error("reserved enable bits not high");
   property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule // wdog_ctl_assertions
bind wdog_ctl wdog_ctl_assertions wdog_ctl_assertions_inst (.clock, .rst_n, .sfr_wr, .sfr_rd, .sfr_addr,
   .sfr_wdata, .sfr_rdata, .wdog_timeout, .wdog_restart_pulse, .wdog_chip_reset, .wdog_irq_priority,
   .ext_irq_enable, .ext_irq_priority, .second_serial_baud_double);
`default_nettype wire

// file: wdog_ctl_test.sv
// Directed testbench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module wdog_ctl_test;
   // Design ports, named as on the block
   logic       clock, rst_n, por_event, power_fail_event, wdog_reset_event, sfr_wr, sfr_rd, wdog_timeout;
   logic [7:0] sfr_addr, sfr_wdata;
   wire  [7:0] sfr_rdata;
   wire  [3:0] ext_irq_enable, ext_irq_priority;
   wire        wdog_restart_pulse, wdog_chip_reset, wdog_irq_req, wdog_irq_priority, second_serial_baud_double;
   int         num_errors, checked, resets;
   wdog_ctl wdog_ctl_inst (.clock, .rst_n, .por_event, .power_fail_event, .wdog_reset_event, .sfr_wr, .sfr_rd,
      .sfr_addr, .sfr_wdata, .sfr_rdata, .wdog_timeout, .wdog_restart_pulse, .wdog_chip_reset, .wdog_irq_req,
      .wdog_irq_priority, .ext_irq_enable, .ext_irq_priority, .second_serial_baud_double);
   // 100 MHz clock
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   // Count chip resets so a missed or doubled pulse changes the total
   always @(posedge clock)
      resets += (rst_n && wdog_chip_reset);
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(logic [7:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %h not %h", $time, got, exp);
         num_errors++;
      end
   endtask
   // Strobe stays high across back-to-back puts; the key only needs no other write between its two bytes
   task automatic put(logic [7:0] a, d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1;
      step(1);
   endtask
   task automatic wr8(logic [7:0] a, d);
      put(a, d);
      sfr_wr = 0;
      step(1);
   endtask
   task automatic rd8(logic [7:0] a, exp);
      sfr_addr = a;
      sfr_rd = 1;
      step(1);
      sfr_rd = 0;
      step(1);
      chk(sfr_rdata, exp);
   endtask
   task automatic reset_as(logic [2:0] kind);
      {por_event, power_fail_event, wdog_reset_event} = kind;
      rst_n = 0;
      step(2);
      rst_n = 1;
   endtask
   task automatic pulse_timeout;
      resets = 0;
      wdog_timeout = 1;
      step(1);
      wdog_timeout = 0;
      step(2);
   endtask
   // Power-on values, then free and keyed control writes
   task automatic t_access;
      rd8(8'he8, 8'he0);
      rd8(8'hf8, 8'h00);
      wr8(8'hd8, 8'hff);
      rd8(8'hd8, 8'hc4);
      put(8'hc7, 8'haa);
      put(8'hc7, 8'h55);
      put(8'hd8, 8'h03);
      chk(8'(wdog_restart_pulse), 8'h01);
      put(8'hd8, 8'h03);
      chk(8'(wdog_restart_pulse), 8'h00);
      sfr_wr = 0;
      step(1);
      rd8(8'hd8, 8'h02);
      put(8'hc7, 8'haa);
      put(8'hc7, 8'h55);
      wr8(8'he8, 8'h00);
      wr8(8'hd8, 8'h00);
      rd8(8'hd8, 8'h02);
      $display("access test done");
   endtask
   // Time-out with interrupt and reset enabled, then a keyed flag clear
   task automatic t_timeout;
      wr8(8'he8, 8'h1f);
      wr8(8'hf8, 8'h1a);
      wr8(8'hd8, 8'h80);
      chk({ext_irq_enable, ext_irq_priority}, 8'hfa);
      chk({6'h00, wdog_irq_priority, second_serial_baud_double}, 8'h03);
      pulse_timeout;
      chk(8'(wdog_irq_req), 8'h01);
      rd8(8'hd8, 8'h8a);
      step(500);
      chk(8'(resets), 8'h00);
      step(20);
      chk(8'(resets), 8'h01);
      put(8'hc7, 8'haa);
      put(8'hc7, 8'h55);
      wr8(8'hd8, 8'h02);
      step(1);
      chk(8'(wdog_irq_req), 8'h00);
      $display("time-out test done");
   endtask
   // Each reset kind against the kept and forced control bits
   task automatic t_resets;
      reset_as(3'b001);
      rd8(8'hd8, 8'h06);
      rd8(8'he8, 8'he0);
      wr8(8'hd8, 8'h86);
      reset_as(3'b000);
      rd8(8'hd8, 8'h06);
      reset_as(3'b010);
      rd8(8'hd8, 8'h02);
      reset_as(3'b100);
      rd8(8'hd8, 8'h40);
      $display("reset test done");
   endtask
   // Time-out with interrupt and reset both off; a watchdog reset then leaves its flag alone
   task automatic t_disabled;
      pulse_timeout;
      chk(8'(wdog_irq_req), 8'h00);
      rd8(8'hd8, 8'h48);
      step(520);
      chk(8'(resets), 8'h00);
      reset_as(3'b001);
      rd8(8'hd8, 8'h40);
      $display("disabled test done");
   endtask
   task automatic give_verdict;
      $display("%0d checks, %0d mismatches", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Main sequence after a 12-cycle power-on reset
   initial
   begin
      {power_fail_event, wdog_reset_event, sfr_wr, sfr_rd, wdog_timeout, sfr_addr, sfr_wdata} = 0;
      rst_n = 0;
      por_event = 1;
      step(12);
      rst_n = 1;
      t_access;
      t_timeout;
      t_resets;
      t_disabled;
      give_verdict;
   end
   // Hang guard; about 1,120 cycles are expected
   initial
   begin
      #60000;
      num_errors++;
      give_verdict;
   end
endmodule // wdog_ctl_test
`default_nettype wire
